// ==== hw/nsc_pkg.sv ====
// Package for the network statistics counter bank: layout, timing and carriers
package nsc_pkg;

  // ****************************************************************
  // Bank layout
  // ****************************************************************
  localparam int          NUM_SLOTS = 8;
  localparam int          IDX_W     = 3;
  localparam int          CNT_W     = 32;
  localparam int          TDR_W     = 16;
  localparam int          ACC_W     = 8;

  // Slot indices of the statistics array
  localparam logic [2:0]  SLOT_TX_OK    = 3'h0;  // frames_sent_ok_count
  localparam logic [2:0]  SLOT_TX_ABORT = 3'h1;  // frames_aborted_collision_count
  localparam logic [2:0]  SLOT_RSVD     = 3'h2;  // reserved_slot
  localparam logic [2:0]  SLOT_TDR      = 3'h3;  // cable_reflection_delay
  localparam logic [2:0]  SLOT_RX_OK    = 3'h4;  // frames_received_ok_count
  localparam logic [2:0]  SLOT_RX_ALIGN = 3'h5;  // frames_misaligned_count
  localparam logic [2:0]  SLOT_RX_CRC   = 3'h6;  // frames_bad_crc_count
  localparam logic [2:0]  SLOT_RX_LOST  = 3'h7;  // frames_lost_count
  localparam logic [2:0]  SLOT_LAST     = 3'h7;

  // Reset and limit values
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;
  localparam logic [31:0] CNT_MAX   = 32'hFFFF_FFFF;
  localparam logic [15:0] TDR_RESET = 16'h0000;
  localparam logic [15:0] TDR_MAX   = 16'hFFFF;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          TDR_UNIT_NS   = 100;
  localparam logic [7:0]  ACC_STEP      = 8'(CLK_PERIOD_NS);
  localparam logic [7:0]  ACC_WRAP      = 8'(TDR_UNIT_NS);
  localparam logic [7:0]  ACC_RESET     = 8'h00;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  // One-cycle event strobes from the transmit and receive engines
  typedef struct packed {
    logic txOk;        // Frame sent, with or without retries
    logic txExcess;    // Transmission abandoned at the sixteenth collision
    logic txStart;     // Transmission begins
    logic collision;   // Collision detected on the current transmission
    logic rxOk;        // Frame received without error
    logic rxAlign;     // Frame length not a whole number of octets
    logic rxCrc;       // Frame failed its CRC check
    logic rxLost;      // Frame dropped, no receive buffer
  } nsc_evt_t;

  // Read or reset call over a contiguous index range
  typedef struct packed {
    logic       valid;
    logic       clear;   // 1: reset the range, 0: read only
    logic [2:0] first;
    logic [2:0] last;
  } nsc_cmd_t;

  // One answer word per object of the range
  typedef struct packed {
    logic        valid;
    logic        last;
    logic        error;
    logic [2:0]  index;
    logic [31:0] data;
  } nsc_rsp_t;

  typedef enum logic [0:0] {
    NSC_IDLE = 1'b0,
    NSC_WALK = 1'b1
  } nsc_state_t;

endpackage : nsc_pkg

// ==== hw/nsc_stats.sv ====
// Network statistics counter bank with range read and range reset call
`timescale 1ns/100ps

// Overview of operation
// - Event counters saturate at their maximum until that object is reset.
// - Every object answers as 32 bits; unused upper bits read as zero.
// - Objects are indexed from 0; one call covers a contiguous index range.
// - A reset call zeroes each selected object; a read call changes nothing.
// - Device reset clears all objects; otherwise they are never cleared implicitly.
// - Reflection delay counts 100 ns ticks from transmit start to collision.
// - Index 0 counts frames sent successfully, with or without retries.
// - Index 1 counts transmissions abandoned after 16 collisions.
// - Index 2 is reserved; its contents carry no meaning.
// - Index 3 holds 16-bit delay from the last excess-collision transmission.
// - Index 4 counts frames received without any error.
// - Index 5 counts misaligned frames, whether accepted or not.
// - Index 6 counts CRC-failed frames, whether accepted or not.
// - Index 7 counts frames dropped for lack of a receive buffer.
module nsc_stats #(
  parameter int NUM_SLOTS = nsc_pkg::NUM_SLOTS
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Event strobes
  input  wire nsc_pkg::nsc_evt_t evt,
  // Statistics call
  input  wire nsc_pkg::nsc_cmd_t cmd,
  output logic                   cmdReady,
  output nsc_pkg::nsc_rsp_t      rsp
);

  // ****************************************************************
  // Storage and call state
  // ****************************************************************
  logic [31:0]         slot_reg [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] evtVec;
  logic [NUM_SLOTS-1:0] clrHit;
  nsc_pkg::nsc_state_t state_reg;
  logic                clear_reg;
  logic [2:0]          idx_reg;
  logic [2:0]          last_reg;
  logic                cmdReady_reg;
  nsc_pkg::nsc_rsp_t   rsp_reg;
  logic                cmdTake;
  logic                cmdBad;

  // Reflection delay measurement
  logic [7:0]          acc_reg;
  logic [7:0]          accSum;
  logic                tick;
  logic                timing_reg;
  logic [15:0]         delay_reg;
  logic [15:0]         coll_reg;
  logic [15:0]         collNow;

  // ****************************************************************
  // Event routing
  // ****************************************************************
  // Misaligned and CRC strobes count regardless of acceptance options
  always_comb
  begin
    evtVec                        = '0;
    evtVec[nsc_pkg::SLOT_TX_OK]    = evt.txOk;
    evtVec[nsc_pkg::SLOT_TX_ABORT] = evt.txExcess;
    evtVec[nsc_pkg::SLOT_TDR]      = evt.txExcess;
    evtVec[nsc_pkg::SLOT_RX_OK]    = evt.rxOk;
    evtVec[nsc_pkg::SLOT_RX_ALIGN] = evt.rxAlign;
    evtVec[nsc_pkg::SLOT_RX_CRC]   = evt.rxCrc;
    evtVec[nsc_pkg::SLOT_RX_LOST]  = evt.rxLost;
  end

  // Reset call hits one object per cycle while walking
  // zero selected object
  always_comb
  begin
    clrHit = '0;
    if (state_reg == nsc_pkg::NSC_WALK && clear_reg)
    begin
      clrHit[idx_reg] = 1'b1;
    end
  end

  // ****************************************************************
  // 100 ns tick generator
  // ****************************************************************
  // A fractional accumulator keeps the tick exact although the unit is
  // two and a half clock periods; ticks land at 120 ns then 80 ns spacing.
  assign accSum = acc_reg + nsc_pkg::ACC_STEP;
  assign tick   = (accSum >= nsc_pkg::ACC_WRAP);

  // Accumulator restarts with every transmission
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      acc_reg <= nsc_pkg::ACC_RESET;
    else if (evt.txStart)
      acc_reg <= nsc_pkg::ACC_RESET;
    else if (tick)
      acc_reg <= 8'(accSum - nsc_pkg::ACC_WRAP);
    else
      acc_reg <= accSum;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      timing_reg <= 1'b0;
      delay_reg  <= nsc_pkg::TDR_RESET;
    end
    else if (evt.txStart)
    begin
      timing_reg <= 1'b1;
      delay_reg  <= nsc_pkg::TDR_RESET;
    end
    else if (evt.collision)
    begin
      timing_reg <= 1'b0;
    end
    else if (timing_reg && tick && delay_reg != nsc_pkg::TDR_MAX)
    begin
      delay_reg <= delay_reg + 16'h0001;
    end
  end

  // keep delay of most recent collision
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      coll_reg <= nsc_pkg::TDR_RESET;
    else if (evt.collision && timing_reg)
      coll_reg <= delay_reg;
  end

  // A collision in the same cycle as the abort still counts as the last one
  assign collNow = (evt.collision && timing_reg) ? delay_reg : coll_reg;

  // ****************************************************************
  // Statistics objects
  // ****************************************************************
  for (genvar i = 0; i < NUM_SLOTS; i++)
  begin : g_slot
    // cleared only by device reset or a reset call
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
        slot_reg[i] <= nsc_pkg::CNT_RESET;
      else if (clrHit[i])
        slot_reg[i] <= nsc_pkg::CNT_RESET;
      else if (i == int'(nsc_pkg::SLOT_TDR))
      begin
        if (evtVec[i])
          slot_reg[i] <= {16'h0000, collNow};
      end
      else if (evtVec[i] && slot_reg[i] != nsc_pkg::CNT_MAX)
        slot_reg[i] <= slot_reg[i] + 32'h0000_0001;
    end
  end

  // ****************************************************************
  // Statistics call sequencer
  // ****************************************************************
  // range must be ordered and inside the array
  assign cmdBad  = (cmd.first > cmd.last) ||
                   ({29'h0, cmd.last} > 32'(NUM_SLOTS - 1));
  assign cmdTake = cmd.valid && cmdReady_reg;

  // walk the range one object per cycle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= nsc_pkg::NSC_IDLE;
      clear_reg <= 1'b0;
      idx_reg   <= nsc_pkg::SLOT_TX_OK;
      last_reg  <= nsc_pkg::SLOT_TX_OK;
    end
    else
    begin
      case (state_reg)
        nsc_pkg::NSC_IDLE:
        begin
          if (cmdTake && !cmdBad)
          begin
            state_reg <= nsc_pkg::NSC_WALK;
            clear_reg <= cmd.clear;
            idx_reg   <= cmd.first;
            last_reg  <= cmd.last;
          end
        end
        nsc_pkg::NSC_WALK:
        begin
          if (idx_reg == last_reg)
          begin
            state_reg <= nsc_pkg::NSC_IDLE;
            clear_reg <= 1'b0;
          end
          else
            idx_reg <= idx_reg + 3'h1;
        end
        default:
          state_reg <= nsc_pkg::NSC_IDLE;
      endcase
    end
  end

  // Ready drops the cycle a good-range call is taken and returns with its last word
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      cmdReady_reg <= 1'b0;
    else if (cmdTake && !cmdBad)
      cmdReady_reg <= 1'b0;
    else if (state_reg == nsc_pkg::NSC_WALK && idx_reg != last_reg)
      cmdReady_reg <= 1'b0;
    else
      cmdReady_reg <= 1'b1;
  end

  // answer word, value before any clear
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rsp_reg <= '0;
    else if (state_reg == nsc_pkg::NSC_WALK)
    begin
      rsp_reg.valid <= 1'b1;
      rsp_reg.last  <= (idx_reg == last_reg);
      rsp_reg.error <= 1'b0;
      rsp_reg.index <= idx_reg;
      rsp_reg.data  <= (idx_reg == nsc_pkg::SLOT_RSVD) ? nsc_pkg::CNT_RESET
                                                      : slot_reg[idx_reg];
    end
    else if (cmdTake && cmdBad)
    begin
      // Bad range answers once and touches nothing
      rsp_reg.valid <= 1'b1;
      rsp_reg.last  <= 1'b1;
      rsp_reg.error <= 1'b1;
      rsp_reg.index <= cmd.first;
      rsp_reg.data  <= nsc_pkg::CNT_RESET;
    end
    else
      rsp_reg <= '0;
  end

  assign cmdReady = cmdReady_reg;
  assign rsp      = rsp_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Saturation instead of wrap: a counter only falls through a reset call
  a_sat_hold: assert property (@(posedge core_clk) disable iff (rst)
    !clrHit[0] |=> slot_reg[0] >= $past(slot_reg[0]))
    else $error("sent counter wrapped");

  a_txok_count: assert property (@(posedge core_clk) disable iff (rst)
    evt.txOk && !clrHit[0] && slot_reg[0] != nsc_pkg::CNT_MAX
    |=> slot_reg[0] == $past(slot_reg[0]) + 32'h0000_0001)
    else $error("sent counter missed a frame");

  a_abort_count: assert property (@(posedge core_clk) disable iff (rst)
    evt.txExcess && !clrHit[1] && slot_reg[1] != nsc_pkg::CNT_MAX
    |=> slot_reg[1] == $past(slot_reg[1]) + 32'h0000_0001)
    else $error("abort counter missed an abort");

  a_clear_wins: assert property (@(posedge core_clk) disable iff (rst)
    state_reg == nsc_pkg::NSC_WALK && clear_reg
    |=> slot_reg[$past(idx_reg)] == nsc_pkg::CNT_RESET)
    else $error("reset call did not zero the object");

  a_read_keeps: assert property (@(posedge core_clk) disable iff (rst)
    state_reg == nsc_pkg::NSC_WALK && !clear_reg && !evtVec[idx_reg]
    |=> slot_reg[$past(idx_reg)] == $past(slot_reg[idx_reg]))
    else $error("read call changed an object");

  a_rsvd_zero: assert property (@(posedge core_clk) disable iff (rst)
    rsp_reg.valid && rsp_reg.index == nsc_pkg::SLOT_RSVD |-> rsp_reg.data == 32'h0)
    else $error("reserved slot answered nonzero");

  a_tdr_capture: assert property (@(posedge core_clk) disable iff (rst)
    evt.txExcess && !clrHit[3] |=> slot_reg[3] == {16'h0000, $past(collNow)})
    else $error("reflection delay not captured");

  a_tick_spacing: assert property (@(posedge core_clk) disable iff (rst)
    evt.txStart ##1 (!evt.txStart && !evt.collision)[*3] |=> delay_reg == 16'h0001)
    else $error("delay tick off pace");

  a_range_walk: assert property (@(posedge core_clk) disable iff (rst)
    cmdTake && !cmdBad |=> ##1 rsp_reg.valid && rsp_reg.index == $past(cmd.first, 2))
    else $error("range walk did not start at first index");

  a_crc_count: assert property (@(posedge core_clk) disable iff (rst)
    evt.rxCrc && !clrHit[6] && slot_reg[6] != nsc_pkg::CNT_MAX
    |=> slot_reg[6] == $past(slot_reg[6]) + 32'h0000_0001)
    else $error("CRC counter missed a frame");

  a_lost_count: assert property (@(posedge core_clk) disable iff (rst)
    evt.rxLost && !clrHit[7] && slot_reg[7] != nsc_pkg::CNT_MAX
    |=> slot_reg[7] == $past(slot_reg[7]) + 32'h0000_0001)
    else $error("lost counter missed a frame");

  a_rxok_count: assert property (@(posedge core_clk) disable iff (rst)
    evt.rxOk && !clrHit[4] && slot_reg[4] != nsc_pkg::CNT_MAX
    |=> slot_reg[4] == $past(slot_reg[4]) + 32'h0000_0001)
    else $error("receive counter missed a frame");

  a_align_count: assert property (@(posedge core_clk) disable iff (rst)
    evt.rxAlign && !clrHit[5] && slot_reg[5] != nsc_pkg::CNT_MAX
    |=> slot_reg[5] == $past(slot_reg[5]) + 32'h0000_0001)
    else $error("alignment counter missed a frame");

  a_tdr_upper: assert property (@(posedge core_clk) disable iff (rst)
    rsp_reg.valid && rsp_reg.index == nsc_pkg::SLOT_TDR |-> rsp_reg.data[31:16] == 16'h0000)
    else $error("delay word upper half not zero");

  a_ready_walk: assert property (@(posedge core_clk) disable iff (rst)
    state_reg == nsc_pkg::NSC_WALK |-> !cmdReady_reg)
    else $error("ready high while walking");

  a_bad_range: assert property (@(posedge core_clk) disable iff (rst)
    cmdTake && cmdBad
    |=> rsp_reg.valid && rsp_reg.error && rsp_reg.last && state_reg == nsc_pkg::NSC_IDLE)
    else $error("bad range not refused");

  a_walk_step: assert property (@(posedge core_clk) disable iff (rst)
    state_reg == nsc_pkg::NSC_WALK && $past(state_reg) == nsc_pkg::NSC_WALK
    |-> idx_reg == $past(idx_reg) + 3'h1)
    else $error("range walk skipped an index");

endmodule : nsc_stats

// ==== tb/nsc_stats_tb.sv ====
// Self-checking testbench for the network statistics counter bank
`timescale 1ns/100ps

`define CHK(g, e, m) \
  begin totalChecks++; if ((g) !== (e)) begin badCount++; \
  $display("BAD %0t %s", $time, m); end end

module testbench;
  // ****************************************************************
  // Signals, clock and watchdog
  // ****************************************************************
  logic              coreClk;
  logic              rst;
  nsc_pkg::nsc_evt_t evt;
  nsc_pkg::nsc_cmd_t cmd;
  logic              cmdReady;
  nsc_pkg::nsc_rsp_t rsp;
  nsc_pkg::nsc_rsp_t got [8];
  logic [31:0]       expv [8];
  logic [7:0]        ev;
  int                rspCnt;
  int                badCount;
  int                totalChecks;
  int                cycles;
  int                slot [6] = '{0, 1, 4, 5, 6, 7};
  int                bitPos [6] = '{7, 6, 3, 2, 1, 0};

  nsc_stats #(.NUM_SLOTS(nsc_pkg::NUM_SLOTS)) uut (
    .core_clk (coreClk),
    .rst      (rst),
    .evt      (evt),
    .cmd      (cmd),
    .cmdReady (cmdReady),
    .rsp      (rsp)
  );

  // 25 MHz clock
  always #20 coreClk = ~coreClk;

  // Whole run needs well under a thousand cycles; a hang is cut off well after that
  always @(posedge coreClk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      badCount++;
      finalReport();
    end
  end

  task automatic finalReport();
    $display("Checks %0d, mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finalReport

  // Hold a strobe pattern for n edges, so n counts land back to back
  task automatic pulse(input logic [7:0] e, input int n);
    @(posedge coreClk);
    evt <= nsc_pkg::nsc_evt_t'(e);
    repeat (n) @(posedge coreClk);
    evt <= '0;
  endtask : pulse

  // One call; hit is raised so that it lands on the edge that clears the first object
  task automatic doCall(input logic clr, input logic [2:0] f, input logic [2:0] l,
                        input logic [7:0] hit);
    int n;
    n = 0;
    rspCnt = 0;
    @(posedge coreClk);
    while (cmdReady !== 1'b1 && n < 50)
    begin
      @(posedge coreClk);
      n++;
    end
    `CHK(cmdReady, 1'b1, "call never ready")
    cmd <= '{1'b1, clr, f, l};
    @(posedge coreClk);
    cmd <= '0;
    evt <= nsc_pkg::nsc_evt_t'(hit);
    for (n = 0; n < 12; n++)
    begin
      #1;
      if (n == 0)
        `CHK(cmdReady, logic'(f > l), "ready after take")
      if (rsp.valid === 1'b1 && rspCnt < 8)
      begin
        got[rspCnt] = rsp;
        rspCnt++;
        if (rsp.last === 1'b1 || rsp.error === 1'b1)
          break;
      end
      @(posedge coreClk);
      evt <= '0;
    end
  endtask : doCall

  // Words must come in ascending order, last one flagged; delay and spare slot skipped
  task automatic checkRange(input logic [2:0] f, input logic [2:0] l);
    `CHK(rspCnt, l - f + 1, "word count")
    for (int k = 0; k < rspCnt; k++)
    begin
      `CHK(got[k].index, 3'(f + k), "index order")
      `CHK(got[k].last, logic'(k == rspCnt - 1), "last flag")
      if (got[k].index != nsc_pkg::SLOT_TDR && got[k].index != nsc_pkg::SLOT_RSVD)
        `CHK(got[k].data, expv[got[k].index], "slot value")
    end
  endtask : checkRange

  // Tick phase restarts with each transmission start, yet one tick either way is accepted
  task automatic checkTdr(input int e);
    `CHK(rspCnt, 1, "delay word")
    `CHK(got[0].data[15:0] >= 16'(e - 1) && got[0].data[15:0] <= 16'(e + 1), 1'b1, "delay")
  endtask : checkTdr

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    coreClk = 1'b0;
    rst = 1'b1;
    evt = '0;
    cmd = '0;
    ev = 8'h00;
    badCount = 0;
    totalChecks = 0;
    cycles = 0;
    foreach (expv[i]) expv[i] = 32'h0000_0000;
    repeat (20) @(posedge coreClk);
    rst <= 1'b0;
    // all objects zero, whole array in one call
    doCall(1'b0, 3'h0, 3'h7, 8'h00);
    checkRange(3'h0, 3'h7);
    // each counter gets its own burst length
    foreach (slot[s])
    begin
      ev = 8'h01 << bitPos[s];
      pulse(ev, s + 2);
      expv[slot[s]] = 32'(s + 2);
    end
    pulse(8'h89, 1);
    expv[0]++;
    expv[4]++;
    expv[7]++;
    doCall(1'b0, 3'h0, 3'h7, 8'h00);
    checkRange(3'h0, 3'h7);
    // reading a sub-range leaves values alone
    doCall(1'b0, 3'h4, 3'h5, 8'h00);
    checkRange(3'h4, 3'h5);
    doCall(1'b0, 3'h4, 3'h5, 8'h00);
    checkRange(3'h4, 3'h5);
    // Reversed range is answered by one error word and changes nothing
    doCall(1'b1, 3'h5, 3'h2, 8'h00);
    `CHK(rspCnt, 1, "bad range words")
    `CHK(got[0].error, 1'b1, "bad range error")
    // clear answers old values, then only the range is zero
    doCall(1'b1, 3'h0, 3'h1, 8'h00);
    checkRange(3'h0, 3'h1);
    expv[0] = 32'h0000_0000;
    expv[1] = 32'h0000_0000;
    doCall(1'b0, 3'h0, 3'h7, 8'h00);
    checkRange(3'h0, 3'h7);
    // receive event on the clearing edge is lost
    doCall(1'b1, 3'h4, 3'h4, 8'h08);
    checkRange(3'h4, 3'h4);
    expv[4] = 32'h0000_0000;
    doCall(1'b0, 3'h4, 3'h4, 8'h00);
    checkRange(3'h4, 3'h4);
    // 252 cycles of 40 ns give about 100 ticks of 100 ns
    pulse(8'h20, 1);
    repeat (250) @(posedge coreClk);
    pulse(8'h50, 1);
    expv[1]++;
    doCall(1'b0, 3'h3, 3'h3, 8'h00);
    checkTdr(100);
    // plain collision does not touch the stored delay
    pulse(8'h20, 1);
    repeat (50) @(posedge coreClk);
    pulse(8'h10, 1);
    doCall(1'b0, 3'h3, 3'h3, 8'h00);
    checkTdr(100);
    // later abort stores the delay held from that collision
    repeat (30) @(posedge coreClk);
    pulse(8'h40, 1);
    expv[1]++;
    doCall(1'b0, 3'h3, 3'h3, 8'h00);
    checkTdr(20);
    doCall(1'b0, 3'h0, 3'h7, 8'h00);
    checkRange(3'h0, 3'h7);
    // reset in mid-run clears the whole array
    @(posedge coreClk);
    rst <= 1'b1;
    repeat (3) @(posedge coreClk);
    rst <= 1'b0;
    foreach (expv[i]) expv[i] = 32'h0000_0000;
    doCall(1'b0, 3'h0, 3'h7, 8'h00);
    checkRange(3'h0, 3'h7);
    `CHK(got[3].data[15:0], 16'h0000, "delay after reset")
    finalReport();
  end
endmodule : testbench
